// ---- pkg/pcs_pkg.sv ----
/*
 Constants for the configuration status, class and identification register block.
 Assumes a byte-addressed configuration space with a 32-bit dword access port.
*/
package pcs_pkg;
	// Byte offsets within configuration space (dword aligned).
	localparam logic [7:0] PCS_OFF_CMD_STATUS = 8'h04;
	localparam logic [7:0] PCS_OFF_CLASS_REV = 8'h08;
	localparam logic [7:0] PCS_OFF_CACHE_LAT = 8'h0c;
	// Status bit positions.
	localparam int PCS_ST_DET_PARITY = 15;
	localparam int PCS_ST_SIG_SYSERR = 14;
	localparam int PCS_ST_RX_MASTER_ABORT = 13;
	localparam int PCS_ST_RX_TARGET_ABORT = 12;
	localparam int PCS_ST_SIG_TARGET_ABORT = 11;
	localparam int PCS_ST_MDPE = 8;
	localparam int PCS_ST_CAPL = 4;
	localparam int PCS_ST_INTS = 3;
	// Command bit positions.
	localparam int PCS_CMD_PERR = 6;
	localparam int PCS_CMD_SERR = 8;
	localparam int PCS_CMD_INTD = 10;
	// Writable status flags (write one to clear).
	localparam logic [15:0] PCS_ST_W1C_MASK = 16'hf900;
	// Reset values and command write mask.
	localparam logic [15:0] PCS_STATUS_RST = 16'h0000;
	localparam logic [15:0] PCS_CMD_RST = 16'h0000;
	localparam logic [15:0] PCS_CMD_WMASK = 16'h0556;
	localparam logic [7:0] PCS_CACHE_LINE_RST = 8'h00;
	// Class codes and latency timer value.
	localparam logic [7:0] PCS_PROG_IF = 8'h00;
	localparam logic [7:0] PCS_SUBCLASS = 8'h80;
	localparam logic [7:0] PCS_BASECLASS = 8'h02;
	localparam logic [7:0] PCS_LAT_TIMER = 8'h00;
	// Revision is arbitrary, not tied to any real part.
	localparam logic [7:0] PCS_REVISION_DEF = 8'h01;
endpackage

// ---- core/pcs_sync3.sv ----
/*
 Three-stage input synchroniser with agreement of the last two stages.
 Assumes an asynchronous input and a single clock domain.
*/
`timescale 1ns/1ns
module pcs_sync3 (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} pcs_sync_st_t;
	pcs_sync_st_t st_q;
	pcs_sync_st_t st_d;
	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.s1 = async_in;
			st_d.s2 = st_q.s1;
			st_d.s3 = st_q.s2;
			if (st_q.s2 == st_q.s3) begin
				st_d.out = st_q.s3;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign sync_out = st_q.out;
endmodule // pcs_sync3

// ---- core/pcs_cfg_regs.sv ----
/*
 Configuration status, command, class and revision registers of an endpoint header.
 Assumes the link core presents one-cycle event pulses on mclk and a dword
 configuration access port; the interrupt source level comes from another domain.
*/
// Operation
// - Sixteen-bit status register, reads unchanged, resets zero.
// - Software only clears flags; hardware sets them.
// - Poisoned TLP received sets detected parity flag.
// - Fatal/nonfatal message with enable sets system flag.
// - Unsupported request completion sets master abort.
// - Completer abort completion sets received target abort.
// - Sending completer abort sets signaled target abort.
// - Bits ten, nine, seven, five read zero.
// - Master parity flag needs response enable set.
// - Capability list bit always reads one.
// - Interrupt status bit mirrors pending interrupt.
// - Interrupt status read only, clears with source.
// - Interrupt disable does not change status bit.
// - Interrupt output only when enabled and pending.
// - Eight-bit read-only revision register.
// - Programming interface reads zero.
// - Subclass reads other network controller.
// - Base class reads network controller.
// - Cache line size read-write, no effect.
// - Latency timer reads zero, writes discarded.
// - Command bit six enables parity response.
// - Command bit eight enables system error.
// - Command bit ten disables legacy interrupt.
`timescale 1ns/1ns
module pcs_cfg_regs
	import pcs_pkg::*;
#(
	parameter logic [7:0] REVISION = PCS_REVISION_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic ev_poisoned_rx,
	input wire logic ev_err_msg_sent,
	input wire logic ev_cpl_ur_rx,
	input wire logic ev_cpl_ca_rx,
	input wire logic ev_cpl_ca_sent,
	input wire logic ev_req_poisoned_cpl,
	input wire logic ev_req_poisoned_wr,
	input wire logic int_source_pending,
	output logic legacy_int,
	output logic parity_error_response_enable,
	output logic system_error_enable,
	output logic interrupt_disable_control
);
	typedef struct packed {
		logic [15:0] status;
		logic [15:0] command;
		logic [7:0] cache_line_size_field;
		logic [31:0] rdata;
		logic ack;
		logic int_out;
	} pcs_regs_st_t;

	pcs_regs_st_t st_q;
	pcs_regs_st_t st_d;
	logic int_pending_sync;

	// Word assembly with byte enables applied.
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] status_view(input logic [15:0] flags, input logic ints);
		logic [15:0] v;
		v = flags & PCS_ST_W1C_MASK;
		v[PCS_ST_CAPL] = 1'b1;
		v[PCS_ST_INTS] = ints;
		return v;
	endfunction

	pcs_sync3 u_int_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.async_in(int_source_pending),
		.sync_out(int_pending_sync)
	);

	always_comb begin
		logic [15:0] set_v;
		logic [15:0] clr_v;
		logic [31:0] wm;
		set_v = '0;
		clr_v = '0;
		wm = '0;
		st_d = st_q;
		if (ce) begin
			st_d.ack = cfg_rd | cfg_wr;
			if (cfg_rd) begin
				unique case (cfg_addr)
					PCS_OFF_CMD_STATUS: st_d.rdata = {status_view(st_q.status, int_pending_sync), st_q.command};
					PCS_OFF_CLASS_REV: st_d.rdata = {PCS_BASECLASS, PCS_SUBCLASS, PCS_PROG_IF, REVISION};
					PCS_OFF_CACHE_LAT: st_d.rdata = {16'h0000, PCS_LAT_TIMER, st_q.cache_line_size_field};
					default: st_d.rdata = 32'h0000_0000;
				endcase
			end
			if (cfg_wr && cfg_addr == PCS_OFF_CMD_STATUS) begin
				wm = merge_be({16'h0000, st_q.command}, cfg_wdata, cfg_be);
				st_d.command = wm[15:0] & PCS_CMD_WMASK;
				if (cfg_be[2]) begin
					clr_v[7:0] = cfg_wdata[23:16];
				end
				if (cfg_be[3]) begin
					clr_v[15:8] = cfg_wdata[31:24];
				end
				clr_v = clr_v & PCS_ST_W1C_MASK;
			end
			if (cfg_wr && cfg_addr == PCS_OFF_CACHE_LAT && cfg_be[0]) begin
				st_d.cache_line_size_field = cfg_wdata[7:0];
			end
			set_v[PCS_ST_DET_PARITY] = ev_poisoned_rx;
			set_v[PCS_ST_SIG_SYSERR] = ev_err_msg_sent & st_q.command[PCS_CMD_SERR];
			set_v[PCS_ST_RX_MASTER_ABORT] = ev_cpl_ur_rx;
			set_v[PCS_ST_RX_TARGET_ABORT] = ev_cpl_ca_rx;
			set_v[PCS_ST_SIG_TARGET_ABORT] = ev_cpl_ca_sent;
			set_v[PCS_ST_MDPE] = st_q.command[PCS_CMD_PERR] & (ev_req_poisoned_cpl | ev_req_poisoned_wr);
			// A set in the same cycle as a clear wins.
			st_d.status = ((st_q.status & ~clr_v) | set_v) & PCS_ST_W1C_MASK;
			st_d.int_out = int_pending_sync & ~st_q.command[PCS_CMD_INTD];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.status <= PCS_STATUS_RST;
			st_q.command <= PCS_CMD_RST;
			st_q.cache_line_size_field <= PCS_CACHE_LINE_RST;
			st_q.rdata <= 32'h0000_0000;
			st_q.ack <= 1'b0;
			st_q.int_out <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg_rdata = st_q.rdata;
	assign cfg_ack = st_q.ack;
	assign legacy_int = st_q.int_out;
	assign parity_error_response_enable = st_q.command[PCS_CMD_PERR];
	assign system_error_enable = st_q.command[PCS_CMD_SERR];
	assign interrupt_disable_control = st_q.command[PCS_CMD_INTD];
endmodule // pcs_cfg_regs

// ---- verification/pcs_asserts.sv ----
/* Port assertions for pcs_cfg_regs.
 Bound to every instance; assumes one clock. */
`timescale 1ns/1ns
module pcs_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic cfg_wr_dummy_unused_n,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic ev_poisoned_rx,
	input wire logic ev_cpl_ur_rx,
	input wire logic legacy_int,
	input wire logic interrupt_disable_control
);
	wire rq = ce && cfg_rd;
	wire rd4 = rq && cfg_addr == 8'h04;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_ack; rq |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle; ce && !cfg_rd && !cfg_wr |=> !cfg_ack; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_dpe; ev_poisoned_rx ##1 !cfg_wr ##1 rd4 |=> cfg_rdata[31]; endproperty
	a_dpe: assert property (p_dpe) else $error("bit 15");
	property p_rma; ev_cpl_ur_rx ##1 !cfg_wr ##1 rd4 |=> cfg_rdata[29]; endproperty
	a_rma: assert property (p_rma) else $error("bit 13");
	property p_fix; rd4 |=> {cfg_rdata[26:25], cfg_rdata[23:20], cfg_rdata[18:16]} == 9'h008; endproperty
	a_fix: assert property (p_fix) else $error("fixed bits");
	property p_class; rq && cfg_addr == 8'h08 |=> cfg_rdata[31:8] == 24'h028000; endproperty
	a_class: assert property (p_class) else $error("class");
	property p_lat; rq && cfg_addr == 8'h0c |=> cfg_rdata[31:8] == 24'h0; endproperty
	a_lat: assert property (p_lat) else $error("latency");
	property p_int; interrupt_disable_control |=> !legacy_int; endproperty
	a_int: assert property (p_int) else $error("irq");
endmodule // pcs_chk
bind pcs_cfg_regs pcs_chk u_chk(.*, .cfg_wr_dummy_unused_n(1'b1));

// ---- verification/pcs_rc_model.sv ----
/* Root complex model issuing one-cycle configuration requests.
 Released address and data lines show the inverse value. */
`timescale 1ns/1ns
module pcs_rc (
	input wire logic mclk,
	output logic cfg_rd = 1'b0,
	output logic cfg_wr = 1'b0,
	output logic [7:0] cfg_addr = 8'h00,
	output logic [3:0] cfg_be = 4'h0,
	output logic [31:0] cfg_wdata = 32'h0,
	input wire logic [31:0] cfg_rdata
);
	task xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] x, output logic [31:0] d);
		@(posedge mclk);
		#1 {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {!w, w, a, b, x};
		@(posedge mclk);
		#1 {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {2'b00, ~a, ~x};
		d = cfg_rdata;
	endtask
endmodule // pcs_rc

// ---- verification/pcie_cfg_status_class_regs_test.sv ----
/* Self-checking bench for pcs_cfg_regs.
 Requests go through the pcs_rc model. */
`timescale 1ns/1ns
module pcie_cfg_status_class_regs_test;
	logic mclk = 1'b0, rst_n = 1'b0, pend = 1'b0;
	logic [6:0] ev = 7'h00;
	logic [31:0] d, r;
	int n_errors = 0, num_checks = 0, cyc = 0;
	wire cfg_rd, cfg_wr, cfg_ack, lint, pe, se, idis;
	wire [7:0] cfg_addr;
	wire [3:0] cfg_be;
	wire [31:0] cfg_wdata, cfg_rdata;
	always #50 mclk = ~mclk;
	pcs_cfg_regs #(.REVISION(8'h5a)) uut(.*, .ce(1'b1), .ev_poisoned_rx(ev[0]), .ev_err_msg_sent(ev[1]),
		.ev_cpl_ur_rx(ev[2]), .ev_cpl_ca_rx(ev[3]), .ev_cpl_ca_sent(ev[4]), .ev_req_poisoned_cpl(ev[5]),
		.ev_req_poisoned_wr(ev[6]), .int_source_pending(pend), .legacy_int(lint),
		.parity_error_response_enable(pe), .system_error_enable(se), .interrupt_disable_control(idis));
	pcs_rc rc(.*);
	function logic [31:0] st(input logic [15:0] f, c);
		return {f | 16'h0010, c};
	endfunction
	task chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rc.xfer(1'b0, a, 4'h0, 32'h0, d);
		chk(n, e, d);
	endtask
	task pulse(input logic [6:0] x);
		@(posedge mclk);
		#1 ev = x;
		@(posedge mclk);
		#1 ev = 7'h00;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up;
		end
	end
	initial begin
		r = $urandom(12358);
		repeat (10) @(posedge mclk);
		#1 rst_n = 1'b1;
		rchk("st", 8'h04, st(16'h0, 16'h0));
		rchk("lt", 8'h0c, 32'h0);
		rc.xfer(1'b1, 8'h04, 4'h3, 32'h0140, d);
		chk("en", 32'h3, {30'h0, pe, se});
		pulse(7'h7f);
		rchk("ev", 8'h04, st(16'hf900, 16'h0140));
		r = $urandom;
		rc.xfer(1'b1, 8'h04, 4'hc, r, d);
		rchk("w1c", 8'h04, st(16'hf900 & ~r[31:16], 16'h0140));
		rc.xfer(1'b1, 8'h04, 4'hf, 32'hffff0000, d);
		chk("dis", 32'h0, {30'h0, pe, se});
		pulse(7'h62);
		rchk("gate", 8'h04, st(16'h0, 16'h0));
		$display("flags done");
		pend = 1'b1;
		#800;
		chk("irq", 32'h1, {31'h0, lint});
		rc.xfer(1'b1, 8'h04, 4'hf, 32'h00080400, d);
		rchk("isd", 8'h04, st(16'h0008, 16'h0400));
		chk("irq", 32'h0, {31'h0, lint});
		chk("intd", 32'h1, {31'h0, idis});
		pend = 1'b0;
		#800;
		rchk("isc", 8'h04, st(16'h0, 16'h0400));
		$display("irq done");
		rc.xfer(1'b1, 8'h0c, 4'hf, r, d);
		rc.xfer(1'b1, 8'h08, 4'hf, r, d);
		rchk("cls", 8'h0c, {24'h0, r[7:0]});
		rchk("id", 8'h08, 32'h0280005a);
		$display("misc done");
		wrap_up;
	end
endmodule // pcie_cfg_status_class_regs_test
